// [logic/nh_defs.svh]
// constants for the nand status/id/reset host controller
// assumes a 10 MHz core clock; times are in ns and rounded up to cycles
`ifndef NH_DEFS_SVH
`define NH_DEFS_SVH

`define NH_CLK_NS 100
`define NH_T_WP_NS 25
`define NH_T_REA_NS 20
`define NH_T_WB_NS 100
`define NH_SYNC_CYC 2
`define NH_WE_CYC ((`NH_T_WP_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_RD_CYC (((`NH_T_REA_NS + `NH_CLK_NS - 1) / `NH_CLK_NS) + `NH_SYNC_CYC)
`define NH_WB_CYC (((`NH_T_WB_NS + `NH_CLK_NS - 1) / `NH_CLK_NS) + `NH_SYNC_CYC)

`define NH_CMD_STATUS 8'h70
`define NH_CMD_ID 8'h90
`define NH_CMD_READ 8'h00
`define NH_CMD_RESET 8'hFF
`define NH_ID_ADDR 8'h00

`define NH_OFF_CTRL 8'h00
`define NH_OFF_WP 8'h04
`define NH_OFF_STAT 8'h08
`define NH_OFF_ID 8'h0C

`define NH_OP_LSB 0
`define NH_CTRL_BUSY 0
`define NH_CTRL_READY 1
`define NH_CTRL_REFUSED 2
`define NH_WP_BIT 0
`define NH_SB_FAIL 0
`define NH_SB_READY 6
`define NH_SB_UNPROT 7
`define NH_STATUS_RST 8'hC0

`endif

// [logic/nh_pkg.sv]
// types shared by the nand host controller
// assumes nh_defs.svh is compiled alongside
`default_nettype none
package nh_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WE_LO = 7'h02,
    ST_WE_HI = 7'h04,
    ST_RD_LO = 7'h08,
    ST_RD_HI = 7'h10,
    ST_WB = 7'h20,
    ST_RB = 7'h40
  } nh_state_e;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_STATUS = 3'h1,
    OP_POLL = 3'h2,
    OP_ID = 3'h3,
    OP_RESET = 3'h4,
    OP_RDCMD = 3'h5
  } nh_op_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } nh_bus_s;
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic output_strobe_n;
    logic wp_n;
    logic io_oe;
    logic [7:0] io_out;
  } nh_pins_s;
  typedef struct packed {
    nh_state_e st;
    nh_op_e op;
    logic [3:0] cnt;
    logic addr_done;
    logic [1:0] nread;
    nh_pins_s p;
    logic [7:0] io_s1;
    logic [7:0] io_s2;
    logic rb_s1;
    logic rb_s2;
    logic wp_req;
    logic refused;
    logic [7:0] status_byte;
    logic [31:0] id;
    logic [31:0] rdata;
  } nh_state_s;
endpackage
`default_nettype wire

// [logic/nh_host_ctrl.sv]
// host controller for the status, id and reset commands of a nand memory
// assumes an async nand on the pins, ready_busy already pulled up outside
// Summary of operation
// - status query sends 70h, then reads the status byte on read cycles.
// - host writes 00h before resuming page data reads after a status poll.
// - id mode is 90h followed by one address cycle of 00h.
// - command FFh resets the device.
// - host never changes write protect while the device is busy.
// - while busy only status query and reset may be issued.
`include "nh_defs.svh"
`default_nettype none
module nh_host_ctrl (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire nh_pkg::nh_bus_s bus,
  output logic [31:0] rdata,
  output logic busy,
  output nh_pkg::nh_pins_s pins,
  input wire logic [7:0] io_in,
  input wire logic ready_busy
);
  localparam logic [3:0] WE_LD = 4'(`NH_WE_CYC - 1);
  localparam logic [3:0] RD_LD = 4'(`NH_RD_CYC - 1);
  localparam logic [3:0] WB_LD = 4'(`NH_WB_CYC - 1);

  nh_pkg::nh_state_s r;
  nh_pkg::nh_state_s next_r;

  function automatic logic op_allowed(input logic [2:0] op, input logic rdy);
    case (op)
      nh_pkg::OP_STATUS, nh_pkg::OP_POLL, nh_pkg::OP_RESET: op_allowed = 1'b1;
      nh_pkg::OP_ID, nh_pkg::OP_RDCMD: op_allowed = rdy;
      default: op_allowed = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] cmd_of(input nh_pkg::nh_op_e op);
    case (op)
      nh_pkg::OP_STATUS: cmd_of = `NH_CMD_STATUS;
      nh_pkg::OP_ID: cmd_of = `NH_CMD_ID;
      nh_pkg::OP_RESET: cmd_of = `NH_CMD_RESET;
      default: cmd_of = `NH_CMD_READ;
    endcase
  endfunction

  logic go;
  logic [2:0] req_op;

  assign req_op = bus.wdata[`NH_OP_LSB +: 3];
  assign go = bus.wr && bus.addr == `NH_OFF_CTRL && r.st == nh_pkg::ST_IDLE;
  assign rdata = r.rdata;
  assign busy = r.st != nh_pkg::ST_IDLE;
  assign pins = r.p;

  always_comb begin
    next_r = r;
    // ready_busy is a wired-or open-drain line, only ever sampled here
    next_r.io_s1 = io_in;
    next_r.io_s2 = r.io_s1;
    next_r.rb_s1 = ready_busy;
    next_r.rb_s2 = r.rb_s1;
    next_r.rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        `NH_OFF_CTRL: begin
          next_r.rdata[`NH_CTRL_BUSY] = busy;
          next_r.rdata[`NH_CTRL_READY] = r.rb_s2;
          next_r.rdata[`NH_CTRL_REFUSED] = r.refused;
        end
        `NH_OFF_WP: next_r.rdata[`NH_WP_BIT] = r.p.wp_n;
        `NH_OFF_STAT: next_r.rdata[7:0] = r.status_byte;
        `NH_OFF_ID: next_r.rdata = r.id;
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    if (bus.wr && bus.addr == `NH_OFF_WP) begin
      next_r.wp_req = bus.wdata[`NH_WP_BIT];
    end
    case (r.st)
      nh_pkg::ST_IDLE: begin
        // protect only moves while idle and ready, never mid program/erase
        if (r.wp_req != r.p.wp_n && r.rb_s2) begin
          next_r.p.wp_n = r.wp_req;
        end
        if (go) begin
          if (op_allowed(req_op, r.rb_s2)) begin
            next_r.refused = 1'b0;
            next_r.op = nh_pkg::nh_op_e'(req_op);
            next_r.addr_done = 1'b0;
            next_r.nread = 2'h0;
            next_r.p.ce_n = 1'b0;
            if (req_op == nh_pkg::OP_POLL) begin
              // status mode persists, so a poll is only read cycles
              next_r.st = nh_pkg::ST_RD_LO;
              next_r.p.output_strobe_n = 1'b0;
              next_r.cnt = RD_LD;
            end else begin
              next_r.st = nh_pkg::ST_WE_LO;
              next_r.p.cle = 1'b1;
              next_r.p.we_n = 1'b0;
              next_r.p.io_oe = 1'b1;
              next_r.p.io_out = cmd_of(nh_pkg::nh_op_e'(req_op));
              next_r.cnt = WE_LD;
            end
          end else begin
            next_r.refused = 1'b1;
          end
        end
      end
      nh_pkg::ST_WE_LO: begin
        next_r.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h0) begin
          next_r.p.we_n = 1'b1;
          next_r.st = nh_pkg::ST_WE_HI;
        end
      end
      nh_pkg::ST_WE_HI: begin
        // data held one full cycle past the rising write strobe
        next_r.p.cle = 1'b0;
        next_r.p.ale = 1'b0;
        next_r.p.io_oe = 1'b0;
        if (r.op == nh_pkg::OP_ID && !r.addr_done) begin
          next_r.addr_done = 1'b1;
          next_r.p.ale = 1'b1;
          next_r.p.io_oe = 1'b1;
          next_r.p.io_out = `NH_ID_ADDR;
          next_r.p.we_n = 1'b0;
          next_r.cnt = WE_LD;
          next_r.st = nh_pkg::ST_WE_LO;
        end else if (r.op == nh_pkg::OP_STATUS || r.op == nh_pkg::OP_ID) begin
          next_r.p.output_strobe_n = 1'b0;
          next_r.cnt = RD_LD;
          next_r.st = nh_pkg::ST_RD_LO;
        end else if (r.op == nh_pkg::OP_RESET) begin
          next_r.cnt = WB_LD;
          next_r.st = nh_pkg::ST_WB;
        end else begin
          next_r.p.ce_n = 1'b1;
          next_r.st = nh_pkg::ST_IDLE;
        end
      end
      nh_pkg::ST_RD_LO: begin
        // strobe held low over access time plus the input synchroniser
        next_r.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h0) begin
          if (r.op == nh_pkg::OP_ID) begin
            next_r.id[{r.nread, 3'h0} +: 8] = r.io_s2;
          end else begin
            next_r.status_byte = r.io_s2;
          end
          next_r.p.output_strobe_n = 1'b1;
          next_r.st = nh_pkg::ST_RD_HI;
        end
      end
      nh_pkg::ST_RD_HI: begin
        if (r.op == nh_pkg::OP_ID && r.nread != 2'h3) begin
          next_r.nread = r.nread + 2'h1;
          next_r.p.output_strobe_n = 1'b0;
          next_r.cnt = RD_LD;
          next_r.st = nh_pkg::ST_RD_LO;
        end else begin
          next_r.p.ce_n = 1'b1;
          next_r.st = nh_pkg::ST_IDLE;
        end
      end
      nh_pkg::ST_WB: begin
        // ready_busy is not valid until the busy window has opened
        next_r.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h0) begin
          next_r.st = nh_pkg::ST_RB;
        end
      end
      nh_pkg::ST_RB: begin
        if (r.rb_s2) begin
          next_r.p.ce_n = 1'b1;
          next_r.status_byte = `NH_STATUS_RST;
          next_r.st = nh_pkg::ST_IDLE;
        end
      end
      default: begin
        next_r.st = nh_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= nh_pkg::ST_IDLE;
      r.op <= nh_pkg::OP_NONE;
      r.p.ce_n <= 1'b1;
      r.p.we_n <= 1'b1;
      r.p.output_strobe_n <= 1'b1;
      r.status_byte <= `NH_STATUS_RST;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge core_clk iff clk_en);
  endclocking
  default disable iff (sys_rst);

  property p_status_cmd;
    (r.st == nh_pkg::ST_WE_LO && r.p.cle && r.op == nh_pkg::OP_STATUS)
      |-> (r.p.io_out == `NH_CMD_STATUS && r.p.io_oe && !r.p.ce_n);
  endproperty
  a_status_cmd: assert property (p_status_cmd)
    else $error("status query did not send 70h");

  property p_status_read;
    ($rose(r.p.we_n) && r.op == nh_pkg::OP_STATUS)
      |-> ##[1:2] (!r.p.output_strobe_n && !r.p.ce_n && !r.p.io_oe);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("no read cycle after status query");

  property p_read_cmd;
    (r.p.cle && !r.p.we_n && r.op == nh_pkg::OP_RDCMD)
      |-> r.p.io_out == `NH_CMD_READ;
  endproperty
  a_read_cmd: assert property (p_read_cmd)
    else $error("read resume command is not 00h");

  property p_id_addr;
    (r.p.ale && !r.p.we_n)
      |-> (r.op == nh_pkg::OP_ID && r.p.io_out == `NH_ID_ADDR && r.addr_done);
  endproperty
  a_id_addr: assert property (p_id_addr)
    else $error("id address cycle wrong");

  property p_reset_cmd;
    (r.p.cle && !r.p.we_n && r.op == nh_pkg::OP_RESET)
      |-> r.p.io_out == `NH_CMD_RESET;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset command is not FFh");

  property p_reset_wait;
    ($rose(r.p.we_n) && r.op == nh_pkg::OP_RESET)
      |=> (r.st == nh_pkg::ST_WB && !r.p.ce_n) [*3];
  endproperty
  a_reset_wait: assert property (p_reset_wait)
    else $error("reset busy window too short");

  property p_wp_hold;
    $changed(r.p.wp_n) |-> ($past(r.rb_s2) && $past(r.st) == nh_pkg::ST_IDLE);
  endproperty
  a_wp_hold: assert property (p_wp_hold)
    else $error("write protect moved while busy");

  property p_busy_cmd;
    ($fell(r.p.ce_n) && !$past(r.rb_s2))
      |-> (r.op inside {nh_pkg::OP_STATUS, nh_pkg::OP_POLL, nh_pkg::OP_RESET});
  endproperty
  a_busy_cmd: assert property (p_busy_cmd)
    else $error("command other than status or reset while busy");

  c_status: cover property (r.st == nh_pkg::ST_RD_HI
    && r.op == nh_pkg::OP_STATUS);
  c_id_last: cover property (r.st == nh_pkg::ST_RD_HI
    && r.op == nh_pkg::OP_ID && r.nread == 2'h3);
  c_reset: cover property (r.st == nh_pkg::ST_RB && r.rb_s2);
endmodule
`default_nettype wire

// [dv/nh_nand_model.sv]
// nand device model: status, id, reset and ready/busy behaviour
// assumes host pins from nh_host_ctrl; ready pull-up is modelled here
`include "nh_defs.svh"
`default_nettype none
module nh_nand_model #(
  parameter int T_RST = 600,
  parameter logic [7:0] MAKER = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV = 8'h3C, // arbitrary value
  parameter logic [7:0] DATA = 8'h5A
) (
  input wire nh_pkg::nh_pins_s pins,
  input wire logic [7:0] bus,
  input wire logic hold,
  input wire logic fail,
  output logic [7:0] io,
  output logic ready_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // 1 die, 2-level, 1 page; 2KB page, 8B spare, 128KB block, x8, 45ns
  localparam logic [31:0] ID = {8'h11, 8'h00, DEV, MAKER};
  logic [1:0] mode = 2'h1;
  logic idw = 1'b0;
  logic abrt = 1'b0;
  logic rst_busy = 1'b0;
  logic fq = 1'b0;
  logic [1:0] ptr = 2'h0;
  logic [7:0] val;
  logic [7:0] last = 8'h00;
  wire en = !pins.ce_n && !pins.output_strobe_n;
  wire opb = hold && !abrt;
  assign ready_busy = !(opb || rst_busy);
  always @(posedge hold) abrt = 1'b0;
  always @(posedge fail) fq = 1'b1;
  always @(posedge pins.we_n) if (!pins.ce_n) begin
    if (pins.cle) begin
      mode = 2'h0;
      idw = 1'b0;
      case (bus)
        `NH_CMD_READ: mode = 2'h1;
        `NH_CMD_STATUS: mode = 2'h2;
        `NH_CMD_ID: idw = 1'b1;
        `NH_CMD_RESET: begin
          abrt = hold;
          fq = 1'b0;
          rst_busy = 1'b1;
          rst_busy <= #(T_RST) 1'b0;
        end
        default: ;
      endcase
    end else if (pins.ale && idw && bus == `NH_ID_ADDR) begin
      mode = 2'h3;
      ptr = 2'h0;
    end
  end
  always @(posedge pins.output_strobe_n) begin
    if (mode == 2'h3 && !pins.ce_n) ptr = ptr + 2'h1;
  end
  always @* begin
    case (mode)
      2'h1: val = DATA;
      2'h2: val = {pins.wp_n, ready_busy, 5'h00, fq};
      2'h3: val = ID[8*ptr +: 8];
      default: val = 8'hE7;
    endcase
  end
  // released bus shows the inverse, never a stale value
  always @* if (en) last = val;
  assign io = en ? val : ~last;
endmodule
`default_nettype wire

// [dv/nh_host_ctrl_tb_top.sv]
// testbench for nh_host_ctrl with a behavioural nand device model
// assumes a 10 MHz core clock and the controller's own register map
`include "nh_defs.svh"
`default_nettype none
module nh_host_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T_RST = 600;
  localparam logic [7:0] MAKER = 8'hA5; // arbitrary value
  localparam logic [7:0] DEV = 8'h3C; // arbitrary value
  localparam logic [7:0] DATA = 8'h5A;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic hold = 1'b0;
  logic fail = 1'b0;
  nh_pkg::nh_bus_s bus = '0;
  nh_pkg::nh_pins_s pins;
  logic [31:0] rdata;
  logic busy;
  logic ready_busy;
  logic [7:0] dev_io;
  wire logic [7:0] io_bus = pins.io_oe ? pins.io_out : dev_io;
  int errors = 0;
  int checks_done = 0;
  always #50 core_clk = ~core_clk;
  nh_host_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .bus(bus), .rdata(rdata), .busy(busy), .pins(pins), .io_in(io_bus),
    .ready_busy(ready_busy));
  nh_nand_model #(.T_RST(T_RST), .MAKER(MAKER), .DEV(DEV), .DATA(DATA))
    dev (.pins(pins), .bus(io_bus), .hold(hold), .fail(fail), .io(dev_io),
    .ready_busy(ready_busy));
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(string name, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic reg_is(string name, logic [7:0] a, logic [31:0] e);
    @(posedge core_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    check(name, e, rdata);
  endtask
  // launch an op and wait for the sequence to finish, bounded
  task automatic op(logic [2:0] c, output int n);
    wr(`NH_OFF_CTRL, {29'h0, c});
    n = 0;
    @(negedge core_clk);
    while (busy !== 1'b0 && n < 300) begin
      n++;
      @(negedge core_clk);
    end
    if (n >= 300) check("busy timeout", 32'h0, 32'h1);
  endtask
  // internal operation seen by the device; allow for the ready sync
  task automatic setb(logic h);
    @(posedge core_clk);
    hold <= h;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic t_powerup;
    int n;
    reg_is("stat reset", `NH_OFF_STAT, 32'hC0);
    reg_is("ctrl idle", `NH_OFF_CTRL, 32'h2);
    reg_is("unmapped", 8'h10, 32'h0);
    op(3'h6, n);
    reg_is("bad op", `NH_OFF_CTRL, 32'h6);
    op(3'h2, n);
    reg_is("poll data", `NH_OFF_STAT, {24'h0, DATA});
    $display("test powerup done");
  endtask
  task automatic t_status;
    int n;
    op(3'h1, n);
    reg_is("stat prot", `NH_OFF_STAT, 32'h40);
    wr(`NH_OFF_WP, 32'h1);
    reg_is("wp applied", `NH_OFF_WP, 32'h1);
    // a write while the enable is low must leave the request untouched
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(`NH_OFF_WP, 32'h0);
    clk_en <= 1'b1;
    reg_is("wp frozen", `NH_OFF_WP, 32'h1);
    op(3'h2, n);
    reg_is("stat live", `NH_OFF_STAT, 32'hC0);
    setb(1'b1);
    op(3'h2, n);
    reg_is("stat busy", `NH_OFF_STAT, 32'h80);
    fail <= 1'b1;
    setb(1'b0);
    op(3'h2, n);
    reg_is("stat fail", `NH_OFF_STAT, 32'hC1);
    $display("test status done");
  endtask
  task automatic t_id;
    int n;
    setb(1'b1);
    op(3'h3, n);
    reg_is("id refused", `NH_OFF_CTRL, 32'h4);
    setb(1'b0);
    op(3'h3, n);
    reg_is("id word", `NH_OFF_ID, {8'h11, 8'h00, DEV, MAKER});
    op(3'h2, n);
    reg_is("id stays", `NH_OFF_STAT, {24'h0, MAKER});
    $display("test id done");
  endtask
  task automatic t_reset;
    int n;
    setb(1'b1);
    op(3'h4, n);
    check("reset busy", 32'h1, {31'h0, n > T_RST / 100});
    op(3'h1, n);
    reg_is("stat after", `NH_OFF_STAT, 32'hC0);
    op(3'h4, n);
    op(3'h4, n);
    check("reset again", 32'h1, {31'h0, n > T_RST / 100});
    op(3'h5, n);
    op(3'h2, n);
    reg_is("read resume", `NH_OFF_STAT, {24'h0, DATA});
    setb(1'b0);
    $display("test reset done");
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_powerup;
    t_status;
    t_id;
    t_reset;
    end_of_test;
  end
  initial begin
    #2000000;
    errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
